// ### rtl/dscp_defines.vh
// constants shared by the serial configuration port design files
`ifndef DSCP_DEFINES_VH
`define DSCP_DEFINES_VH

// instruction byte layout
`define DSCP_INSTR_RW_BIT 7
`define DSCP_INSTR_ADDR_HI 3
`define DSCP_INSTR_ADDR_LO 0
`define DSCP_INSTR_BITS 4'h8

// register addresses and their data phase lengths in bytes
`define DSCP_ADDR_PHASE1 4'h0
`define DSCP_ADDR_PHASE2 4'h1
`define DSCP_ADDR_FREQ1 4'h2
`define DSCP_ADDR_FREQ2 4'h3
`define DSCP_ADDR_DELTA 4'h4
`define DSCP_ADDR_UPDRATE 4'h5
`define DSCP_ADDR_RAMPRATE 4'h6
`define DSCP_ADDR_CONTROL 4'h7
`define DSCP_ADDR_MULT 4'h8
`define DSCP_ADDR_SPARE 4'h9
`define DSCP_ADDR_KEYRAMP 4'ha
`define DSCP_ADDR_CTLDAC 4'hb
`define DSCP_LEN_2 3'h2
`define DSCP_LEN_6 3'h6
`define DSCP_LEN_4 3'h4
`define DSCP_LEN_3 3'h3
`define DSCP_LEN_1 3'h1
`define DSCP_LEN_SPARE 3'h2
`define DSCP_LEN_UNMAPPED 3'h1

// port configuration byte inside the control register transfer
`define DSCP_CFG_BYTE_MSBF 3'h3
`define DSCP_CFG_BYTE_LSBF 3'h0
`define DSCP_CFG_SEPOUT_BIT 0
`define DSCP_CFG_LSBF_BIT 1
`define DSCP_CFG_RESET 2'h0

// write stream word: address, byte index, data
`define DSCP_WORD_WIDTH 15
`define DSCP_FIFO_DEPTH 8
`define DSCP_FIFO_AW 3

// pin synchroniser lanes
`define DSCP_SYNC_WIDTH 5
// serial clock and chip select lanes reset high, at their idle levels, so that
// leaving reset never shows a false serial clock edge
`define DSCP_SYNC_RESET 5'h03
`define DSCP_LANE_SCLK 0
`define DSCP_LANE_CSN 1
`define DSCP_LANE_SDIO 2
`define DSCP_LANE_IORST 3
`define DSCP_LANE_UPD 4

`endif

// ### rtl/dscp_fifo.v
// small flip-flop fifo carrying received write bytes
`default_nettype none
module dscp_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire reset,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wrPtr_r;
  reg [AW:0] rdPtr_r;
  wire full;
  wire empty;
  wire doPush;
  wire doPop;

  assign empty = (wrPtr_r == rdPtr_r);
  assign full = (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]) && (wrPtr_r[AW] != rdPtr_r[AW]);
  assign inReady = ~full;
  assign outValid = ~empty;
  assign doPush = inValid && ~full;
  assign doPop = outReady && ~empty;
  assign outData = mem[rdPtr_r[AW-1:0]];

  always @(posedge clock) begin
    if (doPush) begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      wrPtr_r <= {(AW+1){1'b0}};
      rdPtr_r <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= rdPtr_r + 1'b1;
      end
    end
  end
endmodule // dscp_fifo
`default_nettype wire

// ### rtl/dscp_port.v
// serial configuration port of the synthesizer, sampled on the system clock
//------------------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------------------
`default_nettype none
`include "dscp_defines.vh"
module dscp_port (
  input wire clock,
  input wire reset,
  input wire sclkPin,
  input wire csNPin,
  input wire sdioIn,
  output wire sdioOut,
  output wire sdioOe,
  output wire sdoOut,
  output wire sdoOe,
  input wire ioResetPin,
  input wire updateStrobe,
  output wire readReq,
  output wire [3:0] readAddr,
  output wire [2:0] readIndex,
  input wire [7:0] readData,
  output wire wrValid,
  input wire wrReady,
  output wire [3:0] wrAddr,
  output wire [2:0] wrIndex,
  output wire [7:0] wrData,
  output wire wrInReady,
  output wire wrOverflow,
  output wire separateOutputSelect,
  output wire lsbFirst,
  output wire cycleActive
);
  //----------------------------------------------------------------------------
  // state encoding
  //----------------------------------------------------------------------------
  localparam [0:0] ST_INSTR = 1'b0;
  localparam [0:0] ST_DATA = 1'b1;

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  wire [`DSCP_SYNC_WIDTH-1:0] pinsSync;
  wire sclkSync;
  wire csNSync;
  wire sdioSync;
  wire ioResetSync;
  wire updSync;
  wire sclkRise;
  wire sclkFall;
  wire selected;
  wire [7:0] rxNext;
  wire [3:0] instrAddr;
  wire instrRead;
  wire byteDone;
  wire lastByte;
  wire pushWord;
  wire [`DSCP_WORD_WIDTH-1:0] pushData;
  wire [`DSCP_WORD_WIDTH-1:0] popData;
  wire fifoInReady;
  wire [2:0] cfgIndex;
  wire updRise;

  reg sclkPrev_r;
  reg updPrev_r;
  reg [0:0] state_r;
  reg [2:0] bitCnt_r;
  reg [2:0] byteCnt_r;
  reg [2:0] byteTotal_r;
  reg [7:0] rxShift_r;
  reg [7:0] txShift_r;
  reg [3:0] addr_r;
  reg isRead_r;
  reg readReq_r;
  reg readPend_r;
  reg [2:0] readIndex_r;
  reg sdioOut_r;
  reg sdioOe_r;
  reg sdoOut_r;
  reg sdoOe_r;
  reg sepOut_r;
  reg lsbFirst_r;
  reg [1:0] cfgPend_r;
  reg overflow_r;

  //----------------------------------------------------------------------------
  // pin synchronisers and edge detection
  //----------------------------------------------------------------------------
  dscp_sync #(
    .WIDTH(`DSCP_SYNC_WIDTH),
    .RESET_VAL(`DSCP_SYNC_RESET)
  ) pinSync (
    .clock(clock),
    .reset(reset),
    .asyncIn({updateStrobe, ioResetPin, sdioIn, csNPin, sclkPin}),
    .syncOut(pinsSync)
  );

  assign sclkSync = pinsSync[`DSCP_LANE_SCLK];
  assign csNSync = pinsSync[`DSCP_LANE_CSN];
  assign sdioSync = pinsSync[`DSCP_LANE_SDIO];
  assign ioResetSync = pinsSync[`DSCP_LANE_IORST];
  assign updSync = pinsSync[`DSCP_LANE_UPD];

  always @(posedge clock) begin
    if (reset) begin
      sclkPrev_r <= 1'b1;
      updPrev_r <= 1'b0;
    end else begin
      sclkPrev_r <= sclkSync;
      updPrev_r <= updSync;
    end
  end

  // edges seen while deselected are dropped, so the cycle simply pauses
  assign selected = ~csNSync;
  assign sclkRise = selected && sclkSync && ~sclkPrev_r;
  assign sclkFall = selected && ~sclkSync && sclkPrev_r;
  assign updRise = updSync && ~updPrev_r;

  //----------------------------------------------------------------------------
  // receive shifter and instruction decode
  //----------------------------------------------------------------------------
  assign rxNext = lsbFirst_r ? {sdioSync, rxShift_r[7:1]} : {rxShift_r[6:0], sdioSync};
  assign instrRead = rxNext[`DSCP_INSTR_RW_BIT];
  assign instrAddr = rxNext[`DSCP_INSTR_ADDR_HI:`DSCP_INSTR_ADDR_LO];
  assign byteDone = sclkRise && (state_r == ST_DATA) && (bitCnt_r == 3'h7);
  assign lastByte = (byteCnt_r == byteTotal_r - 3'h1);

  function [2:0] lenOf;
    input [3:0] a;
    begin
      case (a)
        `DSCP_ADDR_PHASE1, `DSCP_ADDR_PHASE2, `DSCP_ADDR_MULT, `DSCP_ADDR_CTLDAC:
          lenOf = `DSCP_LEN_2;
        `DSCP_ADDR_FREQ1, `DSCP_ADDR_FREQ2, `DSCP_ADDR_DELTA:
          lenOf = `DSCP_LEN_6;
        `DSCP_ADDR_UPDRATE, `DSCP_ADDR_CONTROL:
          lenOf = `DSCP_LEN_4;
        `DSCP_ADDR_RAMPRATE:
          lenOf = `DSCP_LEN_3;
        `DSCP_ADDR_KEYRAMP:
          lenOf = `DSCP_LEN_1;
        `DSCP_ADDR_SPARE:
          lenOf = `DSCP_LEN_SPARE;
        default:
          lenOf = `DSCP_LEN_UNMAPPED;
      endcase
    end
  endfunction

  //----------------------------------------------------------------------------
  // cycle sequencer
  //----------------------------------------------------------------------------
  always @(posedge clock) begin
    if (reset || ioResetSync) begin
      // resync clears the sequencer and read fetch only; stored data lives elsewhere
      state_r <= ST_INSTR;
      bitCnt_r <= 3'h0;
      byteCnt_r <= 3'h0;
      byteTotal_r <= 3'h1;
      rxShift_r <= 8'h00;
      addr_r <= 4'h0;
      isRead_r <= 1'b0;
    end else if (sclkRise) begin
      rxShift_r <= rxNext;
      bitCnt_r <= bitCnt_r + 3'h1;
      case (state_r)
        ST_INSTR: begin
          if (bitCnt_r == 3'h7) begin
            state_r <= ST_DATA;
            addr_r <= instrAddr;
            isRead_r <= instrRead;
            byteTotal_r <= lenOf(instrAddr);
            byteCnt_r <= 3'h0;
          end
        end
        ST_DATA: begin
          if (bitCnt_r == 3'h7) begin
            if (lastByte) begin
              state_r <= ST_INSTR;
              byteCnt_r <= 3'h0;
            end else begin
              byteCnt_r <= byteCnt_r + 3'h1;
            end
          end
        end
        default: begin
          state_r <= ST_INSTR;
        end
      endcase
    end
  end

  //----------------------------------------------------------------------------
  // read data fetch and launch
  //----------------------------------------------------------------------------
  always @(posedge clock) begin
    if (reset || ioResetSync) begin
      readReq_r <= 1'b0;
      readPend_r <= 1'b0;
      readIndex_r <= 3'h0;
      txShift_r <= 8'h00;
    end else begin
      readReq_r <= 1'b0;
      readPend_r <= readReq_r;
      if (sclkRise && (state_r == ST_INSTR) && (bitCnt_r == 3'h7) && instrRead) begin
        readReq_r <= 1'b1;
        readIndex_r <= 3'h0;
      end else if (byteDone && isRead_r && !lastByte) begin
        readReq_r <= 1'b1;
        readIndex_r <= byteCnt_r + 3'h1;
      end
      // fetch lands well before the next falling edge at legal clock rates
      if (readPend_r) begin
        txShift_r <= readData;
      end else if (sclkFall && (state_r == ST_DATA) && isRead_r) begin
        txShift_r <= lsbFirst_r ? {1'b0, txShift_r[7:1]} : {txShift_r[6:0], 1'b0};
      end
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      sdioOut_r <= 1'b0;
      sdoOut_r <= 1'b0;
    end else if (sclkFall && (state_r == ST_DATA) && isRead_r) begin
      sdioOut_r <= lsbFirst_r ? txShift_r[0] : txShift_r[7];
      sdoOut_r <= lsbFirst_r ? txShift_r[0] : txShift_r[7];
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      sdioOe_r <= 1'b0;
      sdoOe_r <= 1'b0;
    end else begin
      // both pins float whenever chip select is high
      sdioOe_r <= selected && ~ioResetSync && (state_r == ST_DATA) && isRead_r
                  && ~sepOut_r;
      sdoOe_r <= selected && ~ioResetSync && (state_r == ST_DATA) && isRead_r
                 && sepOut_r;
    end
  end

  //----------------------------------------------------------------------------
  // write stream
  //----------------------------------------------------------------------------
  // a full fifo cannot stall the serial clock, so a dropped byte is flagged
  assign pushWord = byteDone && ~isRead_r;
  assign pushData = {addr_r, byteCnt_r, rxNext};

  dscp_fifo #(
    .WIDTH(`DSCP_WORD_WIDTH),
    .DEPTH(`DSCP_FIFO_DEPTH),
    .AW(`DSCP_FIFO_AW)
  ) wrFifo (
    .clock(clock),
    .reset(reset),
    .inValid(pushWord),
    .inReady(fifoInReady),
    .inData(pushData),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData(popData)
  );

  always @(posedge clock) begin
    if (reset) begin
      overflow_r <= 1'b0;
    end else if (pushWord && ~fifoInReady) begin
      overflow_r <= 1'b1;
    end
  end

  //----------------------------------------------------------------------------
  // port configuration bits
  //----------------------------------------------------------------------------
  assign cfgIndex = lsbFirst_r ? `DSCP_CFG_BYTE_LSBF : `DSCP_CFG_BYTE_MSBF;

  // written value waits for the update strobe, then applies mid-cycle too
  always @(posedge clock) begin
    if (reset) begin
      cfgPend_r <= `DSCP_CFG_RESET;
      sepOut_r <= 1'b0;
      lsbFirst_r <= 1'b0;
    end else begin
      if (pushWord && (addr_r == `DSCP_ADDR_CONTROL) && (byteCnt_r == cfgIndex)) begin
        cfgPend_r <= rxNext[1:0];
      end
      if (updRise) begin
        sepOut_r <= cfgPend_r[`DSCP_CFG_SEPOUT_BIT];
        lsbFirst_r <= cfgPend_r[`DSCP_CFG_LSBF_BIT];
      end
    end
  end

  //----------------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------------
  assign sdioOut = sdioOut_r;
  assign sdioOe = sdioOe_r;
  assign sdoOut = sdoOut_r;
  assign sdoOe = sdoOe_r;
  assign readReq = readReq_r;
  assign readAddr = addr_r;
  assign readIndex = readIndex_r;
  assign wrAddr = popData[14:11];
  assign wrIndex = popData[10:8];
  assign wrData = popData[7:0];
  assign wrInReady = fifoInReady;
  assign wrOverflow = overflow_r;
  assign separateOutputSelect = sepOut_r;
  assign lsbFirst = lsbFirst_r;
  assign cycleActive = (state_r == ST_DATA) || (bitCnt_r != 3'h0);
endmodule // dscp_port
`default_nettype wire

// ### rtl/dscp_sync.v
// two-flop synchroniser for asynchronous pin levels
`default_nettype none
module dscp_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // stage1 feeds stage2 only
  always @(posedge clock) begin
    if (reset) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
    end
  end

  assign syncOut = stage2_r;
endmodule // dscp_sync
`default_nettype wire

// ### tb/dscp_assertions.sv
// concurrent checks on the serial configuration port top module
`default_nettype none
module dscp_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic csNPin,
  input wire logic ioResetPin,
  input wire logic updateStrobe,
  input wire logic sdioOut,
  input wire logic sdioOe,
  input wire logic sdoOut,
  input wire logic sdoOe,
  input wire logic readReq,
  input wire logic wrValid,
  input wire logic wrReady,
  input wire logic [3:0] wrAddr,
  input wire logic [7:0] wrData,
  input wire logic wrOverflow,
  input wire logic separateOutputSelect,
  input wire logic lsbFirst,
  input wire logic cycleActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  //------------------------------------------------------------
  // helper: cycles since the update strobe was last high
  //------------------------------------------------------------
  logic [3:0] strobeAge_r;
  always @(posedge clock) begin
    if (reset || updateStrobe) strobeAge_r <= 4'h0;
    else if (strobeAge_r != 4'hf) strobeAge_r <= strobeAge_r + 4'h1;
  end
  a_cs_tristate: assert property (csNPin [*5] |-> !sdioOe && !sdoOe)
    else $error("data pin driven while deselected");
  a_bidir_sdo_off: assert property (!separateOutputSelect && $past(!separateOutputSelect)
    |-> !sdoOe) else $error("separate pin driven in bidirectional mode");
  a_sep_sdio_off: assert property (separateOutputSelect && $past(separateOutputSelect)
    |-> !sdioOe) else $error("data pin driven in separate output mode");
  a_drive_in_data: assert property ((sdioOe || sdoOe) |-> $past(cycleActive))
    else $error("data pin driven outside a data phase");
  a_fetch_pulse: assert property (readReq |=> !readReq)
    else $error("read request longer than one cycle");
  a_resync_idle: assert property (ioResetPin [*5] |-> !cycleActive && !sdioOe && !sdoOe)
    else $error("resync did not end the cycle");
  a_resync_cfg: assert property (ioResetPin && !updateStrobe
    |=> $stable(lsbFirst) && $stable(separateOutputSelect))
    else $error("resync changed the configuration");
  a_cfg_strobe: assert property ($changed(lsbFirst) || $changed(separateOutputSelect)
    |-> strobeAge_r < 4'h6) else $error("configuration changed without update");
  a_ovf_sticky: assert property (wrOverflow |=> wrOverflow)
    else $error("overflow flag cleared");
  a_word_hold: assert property (wrValid && !wrReady
    |=> wrValid && $stable(wrData) && $stable(wrAddr))
    else $error("write word changed while stalled");
endmodule // dscp_assertions
bind dscp_port dscp_assertions chk_u (.clock, .reset, .csNPin, .ioResetPin, .updateStrobe,
  .sdioOut, .sdioOe, .sdoOut, .sdoOe, .readReq, .wrValid, .wrReady, .wrAddr, .wrData,
  .wrOverflow, .separateOutputSelect, .lsbFirst, .cycleActive);
`default_nettype wire

// ### tb/dscp_ctrl_model.sv
// system controller model acting as serial bus master
`default_nettype none
module dscp_ctrl_model (
  output logic sclkPin,
  output logic csNPin,
  output logic ioResetPin,
  output logic sdioDrv,
  input wire logic sdioLine,
  input wire logic sdoLine
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclkPin = 1'b1;
    csNPin = 1'b0;
    ioResetPin = 1'b0;
    sdioDrv = 1'b0;
  end
  // sclk idles high so nothing moves between bytes; 125 ns period
  task automatic xfer(input logic [7:0] tx, input logic lsb, input logic rd,
                      input logic useSdo, output logic [7:0] rx);
    int i;
    for (i = 0; i < 8; i++) begin
      sclkPin = 1'b0;
      // released line toggles so a stale bit never passes
      sdioDrv = rd ? ~sdioDrv : tx[lsb ? i : 7 - i];
      #62.5;
      rx[lsb ? i : 7 - i] = useSdo ? sdoLine : sdioLine;
      sclkPin = 1'b1;
      #62.5;
    end
  endtask
  task automatic setCs(input logic v);
    csNPin = v;
  endtask
  task automatic resync();
    ioResetPin = 1'b1;
    #200;
    ioResetPin = 1'b0;
    #200;
  endtask
endmodule // dscp_ctrl_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the serial configuration port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic updateStrobe = 1'b0;
  logic wrReady = 1'b0;
  logic [7:0] readData = 8'h00;
  logic [7:0] rx;
  int errors = 0;
  int tests_run = 0;
  int k;
  wire sclkPin, csNPin, ioResetPin, sdioDrv, sdioOut, sdioOe, sdoOut, sdoOe, readReq;
  wire wrValid, wrInReady, wrOverflow, separateOutputSelect, lsbFirst, cycleActive;
  wire [3:0] readAddr, wrAddr;
  wire [2:0] readIndex, wrIndex;
  wire [7:0] wrData;
  wire sdioLine = sdioOe ? sdioOut : sdioDrv;
  wire sdoLine = sdoOe ? sdoOut : ~sdoOut;
  always #5 clock = ~clock;
  always @(negedge clock) readData <= {readAddr, 1'b0, readIndex};
  dscp_ctrl_model ctl_u (.sclkPin(sclkPin), .csNPin(csNPin), .ioResetPin(ioResetPin),
    .sdioDrv(sdioDrv), .sdioLine(sdioLine), .sdoLine(sdoLine));
  dscp_port dut_u (.clock(clock), .reset(reset), .sclkPin(sclkPin), .csNPin(csNPin),
    .sdioIn(sdioLine), .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe),
    .ioResetPin(ioResetPin), .updateStrobe(updateStrobe), .readReq(readReq),
    .readAddr(readAddr), .readIndex(readIndex), .readData(readData), .wrValid(wrValid),
    .wrReady(wrReady), .wrAddr(wrAddr), .wrIndex(wrIndex), .wrData(wrData),
    .wrInReady(wrInReady), .wrOverflow(wrOverflow),
    .separateOutputSelect(separateOutputSelect), .lsbFirst(lsbFirst),
    .cycleActive(cycleActive));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input int n, input logic [7:0] base);
    int i;
    ctl_u.xfer({1'b0, 3'h7, a}, 1'b0, 1'b0, 1'b0, rx);
    for (i = 0; i < n; i++) ctl_u.xfer(base + i[7:0], 1'b0, 1'b0, 1'b0, rx);
  endtask
  task automatic rd(input logic [3:0] a, input int n, input logic lsb, input logic sdo,
                    input logic brk);
    int i;
    ctl_u.xfer({1'b1, 3'h5, a}, lsb, 1'b0, 1'b0, rx);
    for (i = 0; i < n; i++) begin
      if (brk && i == 1) begin
        ctl_u.setCs(1'b1);
        repeat (10) @(negedge clock);
        chk("oeWhileDeselected", {sdioOe, sdoOe, cycleActive}, 16'h1);
        ctl_u.setCs(1'b0);
      end
      ctl_u.xfer(8'h00, lsb, 1'b1, sdo, rx);
      chk("readByte", rx, {a, 1'b0, i[2:0]});
    end
  endtask
  task automatic popw(input logic [3:0] a, input int i, input logic [7:0] d);
    int n;
    n = 0;
    while (wrValid !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk("wrWord", {wrAddr, 1'b0, wrIndex, wrData}, {a, 1'b0, i[2:0], d});
    @(negedge clock) wrReady = 1'b1;
    @(negedge clock) wrReady = 1'b0;
  endtask
  task automatic wcfg(input logic [7:0] v);
    wrReady = 1'b1;
    wr(4'h7, 3, 8'h00);
    ctl_u.xfer(v, 1'b0, 1'b0, 1'b0, rx);
    @(negedge clock) updateStrobe = 1'b1;
    repeat (10) @(negedge clock);
    updateStrobe = 1'b0;
    wrReady = 1'b0;
    repeat (5) @(negedge clock);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    chk("cfgReset", {lsbFirst, separateOutputSelect}, 16'h0);
    wr(4'ha, 1, 8'h5c);
    popw(4'ha, 0, 8'h5c);
    $display("test single write done");
    wr(4'h2, 6, 8'h10);
    wr(4'h0, 2, 8'h20);
    repeat (5) @(negedge clock);
    chk("fullReady", wrInReady, 16'h0);
    wr(4'ha, 1, 8'hee);
    repeat (5) @(negedge clock);
    chk("overflow", wrOverflow, 16'h1);
    for (k = 0; k < 6; k++) popw(4'h2, k, 8'h10 + k[7:0]);
    for (k = 0; k < 2; k++) popw(4'h0, k, 8'h20 + k[7:0]);
    chk("drained", wrValid, 16'h0);
    $display("test fifo fill done");
    rd(4'h6, 3, 1'b0, 1'b0, 1'b0);
    rd(4'h5, 4, 1'b0, 1'b0, 1'b1);
    $display("test reads done");
    wr(4'h2, 1, 8'h33);
    ctl_u.resync();
    chk("resyncIdle", cycleActive, 16'h0);
    popw(4'h2, 0, 8'h33);
    wr(4'ha, 1, 8'h44);
    popw(4'ha, 0, 8'h44);
    $display("test resync done");
    wcfg(8'h01);
    chk("sepSelect", {lsbFirst, separateOutputSelect}, 16'h1);
    rd(4'ha, 1, 1'b0, 1'b1, 1'b0);
    wcfg(8'h02);
    chk("lsbSelect", {lsbFirst, separateOutputSelect}, 16'h2);
    rd(4'hb, 2, 1'b1, 1'b0, 1'b0);
    // control register written lsb-first: only byte 0 carries the port bits now
    wrReady = 1'b1;
    ctl_u.xfer(8'h07, 1'b1, 1'b0, 1'b0, rx);
    for (k = 0; k < 4; k++) ctl_u.xfer((k == 0) ? 8'h00 : 8'h03, 1'b1, 1'b0, 1'b0, rx);
    @(negedge clock) updateStrobe = 1'b1;
    repeat (10) @(negedge clock);
    updateStrobe = 1'b0;
    repeat (5) @(negedge clock);
    chk("cfgBack", {lsbFirst, separateOutputSelect}, 16'h0);
    $display("test config done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
